// ===== src/eth_rx_descriptor_fetch.sv
// Operation
// - suppress bit blocks receive interrupt flag
// - ring end returns to list base
// - chain flag makes word 3 next pointer
// - ring end beats chain flag
// - chained descriptor ignores second size
// - first buffer size is bits 12:0
// - zero first size skips buffer one
// - word 2 addresses buffer one
// - word 3 addresses next descriptor when chained
// - word 4 flags dropped timestamp
// - word 4 records message version
// - word 4 records ethernet or udp
// - word 4 records ipv4 or ipv6
// - word 4 carries message type
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "rx_desc_defines.svh"
module eth_rx_descriptor_fetch import rx_desc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic mem_rd_req,
  output word_t mem_rd_addr,
  input wire logic mem_rd_valid,
  input wire word_t mem_rd_data,
  output logic mem_wr_req,
  output word_t mem_wr_addr,
  output word_t mem_wr_data,
  input wire logic mem_wr_ack,
  output logic buf_valid,
  output word_t buf1_addr,
  output bsize_t buf1_size,
  output word_t buf2_addr,
  output bsize_t buf2_size,
  input wire logic frame_end,
  input wire logic frame_ts_dropped,
  input wire logic frame_ptp_v2,
  input wire logic frame_ptp_over_eth,
  input wire logic frame_ptp_ipv4,
  input wire logic frame_ptp_ipv6,
  input wire logic [3:0] frame_ptp_msg_type,
  output logic irq
);
  function automatic word_t apply_strb(input word_t old, input word_t nw, input logic [3:0] st);
    word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `REG_CTRL) || (a == `REG_BASE) || (a == `REG_CUR) ||
      (a == `REG_STATUS) || (a == `REG_CLEAR) || (a == `REG_ENABLE) ||
      (a == `REG_BUFINFO);
  endfunction : is_mapped

  fetch_state_e state_q;
  logic [1:0] word_idx_q;
  word_t cur_q, word1_q, word2_q, word3_q, ctrl_q, base_q;
  logic [`STATUS_W-1:0] status_q, enable_q, clr_pulse, set_pulse;
  logic aw_hold_q, w_hold_q, wr_fire, run, dec_no_buffer, frame_done;
  logic [7:0] awaddr_q;
  word_t wdata_q, dec_buf1_addr, dec_buf2_addr, dec_next, status_word4;
  logic [3:0] wstrb_q;
  bsize_t dec_buf1_size, dec_buf2_size;

  assign run = ctrl_q[`CTRL_RUN_BIT];
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign frame_done = (state_q == ST_RECV) && frame_end;

  rx_desc_decode u_decode (
    .word1(word1_q),
    .word2(word2_q),
    .word3(word3_q),
    .cur_addr(cur_q),
    .base_addr(base_q),
    .buf1_addr(dec_buf1_addr),
    .buf1_size(dec_buf1_size),
    .buf2_addr(dec_buf2_addr),
    .buf2_size(dec_buf2_size),
    .no_buffer(dec_no_buffer),
    .next_addr(dec_next)
  );

  rx_desc_status u_status (
    .ts_dropped(frame_ts_dropped),
    .ptp_v2(frame_ptp_v2),
    .ptp_over_eth(frame_ptp_over_eth),
    .ptp_ipv4(frame_ptp_ipv4),
    .ptp_ipv6(frame_ptp_ipv6),
    .ptp_msg_type(frame_ptp_msg_type),
    .word4(status_word4)
  );

  // axi write address and data capture, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // software-writable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
      base_q <= '0;
      enable_q <= '0;
    end else if (ce && wr_fire) begin
      case (awaddr_q)
        `REG_CTRL: ctrl_q <= apply_strb(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0001;
        `REG_BASE: base_q <= apply_strb(base_q, wdata_q, wstrb_q);
        `REG_ENABLE: enable_q <= wdata_q[`STATUS_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    clr_pulse = '0;
    if (wr_fire && (awaddr_q == `REG_CLEAR)) begin
      clr_pulse = wdata_q[`STATUS_W-1:0];
    end
    set_pulse = '0;
    set_pulse[`ST_FRAME_BIT] = frame_done && !word1_q[`W1_SUPPRESS_BIT];
    set_pulse[`ST_TSDROP_BIT] = frame_done && frame_ts_dropped;
    set_pulse[`ST_SKIP_BIT] = (state_q == ST_DECIDE) && dec_no_buffer;
  end

  // sticky status, a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      status_q <= (status_q & ~clr_pulse) | set_pulse;
      irq <= |(((status_q & ~clr_pulse) | set_pulse) & enable_q);
    end
  end

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_araddr)
          `REG_CTRL: s_axi_rdata <= ctrl_q;
          `REG_BASE: s_axi_rdata <= base_q;
          `REG_CUR: s_axi_rdata <= cur_q;
          `REG_STATUS: s_axi_rdata <= {29'h0000_0000, status_q};
          `REG_ENABLE: s_axi_rdata <= {29'h0000_0000, enable_q};
          `REG_BUFINFO: s_axi_rdata <= {3'h0, buf2_size, 3'h0, buf1_size};
          default: s_axi_rdata <= '0;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // descriptor walk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      word_idx_q <= 2'h1;
      cur_q <= '0;
      word1_q <= '0;
      word2_q <= '0;
      word3_q <= '0;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (run) begin
            cur_q <= base_q;
            word_idx_q <= 2'h1;
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (mem_rd_req && mem_rd_valid) begin
            case (word_idx_q)
              2'h1: word1_q <= mem_rd_data;
              2'h2: word2_q <= mem_rd_data;
              default: word3_q <= mem_rd_data;
            endcase
            if (word_idx_q == 2'h3) begin
              state_q <= ST_DECIDE;
            end else begin
              word_idx_q <= word_idx_q + 2'h1;
            end
          end
        end
        ST_DECIDE: begin
          word_idx_q <= 2'h1;
          if (dec_no_buffer) begin
            cur_q <= dec_next;
            state_q <= run ? ST_FETCH : ST_IDLE;
          end else begin
            state_q <= ST_RECV;
          end
        end
        ST_RECV: begin
          if (frame_end) begin
            state_q <= ST_WBACK;
          end else if (!run) begin
            state_q <= ST_IDLE;
          end
        end
        ST_WBACK: begin
          if (mem_wr_ack) begin
            cur_q <= dec_next;
            word_idx_q <= 2'h1;
            state_q <= run ? ST_FETCH : ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // descriptor read port, held until answered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_rd_req <= 1'b0;
      mem_rd_addr <= '0;
    end else if (ce) begin
      if (mem_rd_req && mem_rd_valid) begin
        mem_rd_req <= 1'b0;
      end else if (state_q == ST_FETCH && !mem_rd_req) begin
        mem_rd_req <= 1'b1;
        mem_rd_addr <= cur_q + {28'h000_0000, word_idx_q, 2'h0};
      end
    end
  end

  // buffer hand-off to the receive path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_valid <= 1'b0;
      buf1_addr <= '0;
      buf1_size <= '0;
      buf2_addr <= '0;
      buf2_size <= '0;
    end else if (ce) begin
      if (state_q == ST_DECIDE && !dec_no_buffer) begin
        buf_valid <= 1'b1;
        buf1_addr <= dec_buf1_addr;
        buf1_size <= dec_buf1_size;
        buf2_addr <= dec_buf2_addr;
        buf2_size <= dec_buf2_size;
      end else if (state_q == ST_RECV && (frame_end || !run)) begin
        buf_valid <= 1'b0;
      end
    end
  end

  // word 4 write-back after the frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_wr_req <= 1'b0;
      mem_wr_addr <= '0;
      mem_wr_data <= '0;
    end else if (ce) begin
      if (frame_done) begin
        mem_wr_req <= 1'b1;
        mem_wr_addr <= cur_q + `WORD4_OFFSET;
        mem_wr_data <= status_word4;
      end else if (mem_wr_req && mem_wr_ack) begin
        mem_wr_req <= 1'b0;
      end
    end
  end
endmodule : eth_rx_descriptor_fetch

// ===== src/rx_desc_decode.sv
`timescale 1ns/1ns
`include "rx_desc_defines.svh"
module rx_desc_decode import rx_desc_pkg::*; (
  input wire word_t word1,
  input wire word_t word2,
  input wire word_t word3,
  input wire word_t cur_addr,
  input wire word_t base_addr,
  output word_t buf1_addr,
  output bsize_t buf1_size,
  output word_t buf2_addr,
  output bsize_t buf2_size,
  output logic no_buffer,
  output word_t next_addr
);
  logic ring_end_flag;
  logic chain_second_address;
  bsize_t first_buffer_size;
  bsize_t second_buffer_size;

  assign ring_end_flag = word1[`W1_RING_END_BIT];
  assign chain_second_address = word1[`W1_CHAIN_BIT];
  assign first_buffer_size = word1[`W1_SIZE1_HI:`W1_SIZE1_LO];
  assign second_buffer_size = chain_second_address ? '0 : word1[`W1_SIZE2_HI:`W1_SIZE2_LO];
  assign buf1_addr = word2;
  assign buf1_size = first_buffer_size;
  assign buf2_addr = word3;
  assign buf2_size = second_buffer_size;
  assign no_buffer = (first_buffer_size == '0) && (second_buffer_size == '0);

  always_comb begin
    if (ring_end_flag) begin
      next_addr = base_addr;
    end else if (chain_second_address) begin
      next_addr = word3;
    end else begin
      next_addr = cur_addr + `DESC_STRIDE;
    end
  end
endmodule : rx_desc_decode

// ===== src/rx_desc_defines.svh
`ifndef RX_DESC_DEFINES_SVH
`define RX_DESC_DEFINES_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_BASE 8'h04
`define REG_CUR 8'h08
`define REG_STATUS 8'h0C
`define REG_CLEAR 8'h10
`define REG_ENABLE 8'h14
`define REG_BUFINFO 8'h18

// control and status fields
`define CTRL_RUN_BIT 0
`define ST_FRAME_BIT 0
`define ST_TSDROP_BIT 1
`define ST_SKIP_BIT 2
`define STATUS_W 3

// descriptor word 1 fields
`define W1_SUPPRESS_BIT 31
`define W1_RING_END_BIT 15
`define W1_CHAIN_BIT 14
`define W1_SIZE2_HI 28
`define W1_SIZE2_LO 16
`define W1_SIZE1_HI 12
`define W1_SIZE1_LO 0

// descriptor word 4 fields
`define W4_TSDROP_BIT 14
`define W4_VER_BIT 13
`define W4_ETH_BIT 12
`define W4_TYPE_HI 11
`define W4_TYPE_LO 8
`define W4_IPV6_BIT 7
`define W4_IPV4_BIT 6

// descriptor layout in bytes
`define DESC_STRIDE 32'h0000_0020
`define WORD4_OFFSET 32'h0000_0010

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== src/rx_desc_pkg.sv
package rx_desc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_DECIDE = 3'b010,
    ST_RECV = 3'b011,
    ST_WBACK = 3'b100
  } fetch_state_e;

  typedef logic [31:0] word_t;
  typedef logic [12:0] bsize_t;
endpackage : rx_desc_pkg

// ===== src/rx_desc_status.sv
`timescale 1ns/1ns
`include "rx_desc_defines.svh"
module rx_desc_status import rx_desc_pkg::*; (
  input wire logic ts_dropped,
  input wire logic ptp_v2,
  input wire logic ptp_over_eth,
  input wire logic ptp_ipv4,
  input wire logic ptp_ipv6,
  input wire logic [3:0] ptp_msg_type,
  output word_t word4
);
  logic is_ptp;
  logic over_udp;

  assign is_ptp = (ptp_msg_type != 4'h0);
  assign over_udp = is_ptp && !ptp_over_eth;

  always_comb begin
    word4 = '0;
    word4[`W4_TSDROP_BIT] = ts_dropped;
    word4[`W4_VER_BIT] = is_ptp && ptp_v2;
    word4[`W4_ETH_BIT] = is_ptp && ptp_over_eth;
    word4[`W4_TYPE_HI:`W4_TYPE_LO] = ptp_msg_type;
    word4[`W4_IPV6_BIT] = over_udp && ptp_ipv6;
    word4[`W4_IPV4_BIT] = over_udp && ptp_ipv4;
  end
endmodule : rx_desc_status

// ===== verif/eth_rx_descriptor_fetch_tb_top.sv
`timescale 1ns/1ns
module eth_rx_descriptor_fetch_tb_top import rx_desc_pkg::*;;
  logic aclk = 0, aresetn = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, frame_end = 0, slow = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF, frame_ptp_msg_type = 4'h0;
  logic frame_ts_dropped = 0, frame_ptp_v2 = 0, frame_ptp_over_eth = 0;
  logic frame_ptp_ipv4 = 0, frame_ptp_ipv6 = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic mem_rd_req, mem_rd_valid, mem_wr_req, mem_wr_ack, buf_valid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  word_t s_axi_rdata, mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data, buf1_addr, buf2_addr, d;
  bsize_t buf1_size, buf2_size;
  int fails = 0, compares = 0, cyc = 0;

  eth_rx_descriptor_fetch u_dut (.*);
  rx_host_mem_model u_mem (.*);

  initial begin
    forever #25 aclk = ~aclk;
  end

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input word_t s, input word_t e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input word_t v);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready) begin
        s_axi_awvalid <= 0;
        pa = 0;
      end
      if (pw && s_axi_wready) begin
        s_axi_wvalid <= 0;
        pw = 0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : axr

  task automatic frm(input word_t a1, s1, a2, s2, input logic [8:0] f, input word_t wa, w4);
    do @(posedge aclk); while (!buf_valid);
    chk("buf1_addr", buf1_addr, a1);
    chk("buf1_size", 32'(buf1_size), s1);
    chk("buf2_addr", buf2_addr, a2);
    chk("buf2_size", 32'(buf2_size), s2);
    frame_end <= 1;
    {frame_ts_dropped, frame_ptp_v2, frame_ptp_over_eth, frame_ptp_ipv4, frame_ptp_ipv6,
      frame_ptp_msg_type} <= f;
    @(posedge aclk);
    frame_end <= 0;
    do @(posedge aclk); while (!(mem_wr_req && mem_wr_ack));
    chk("wb_addr", mem_wr_addr, wa);
    chk("word4", mem_wr_data, w4);
    $display("frame test done");
  endtask : frm

  initial begin
    u_mem.mem[65] = 32'h8080_0040;
    u_mem.mem[66] = 32'h0000_1000;
    u_mem.mem[67] = 32'h0000_2000;
    u_mem.mem[73] = 32'h1FFF_4020;
    u_mem.mem[74] = 32'h0000_1100;
    u_mem.mem[75] = 32'h0000_0300;
    u_mem.mem[193] = 32'h0000_4000;
    u_mem.mem[195] = 32'h0000_0340;
    u_mem.mem[209] = 32'h0000_C010;
    u_mem.mem[210] = 32'h0000_1200;
    u_mem.mem[211] = 32'h0000_0500;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    chk("rst_ready", 32'({s_axi_awready, s_axi_wready, s_axi_arready}), 32'h7);
    chk("rst_idle", 32'({s_axi_bvalid, s_axi_rvalid, buf_valid, mem_rd_req, mem_wr_req, irq}), 32'h0);
    axr(8'h0C);
    chk("status_rst", d, 32'h0);
    axr(8'h1C);
    chk("rresp", 32'(r), 32'h2);
    axw(8'h20, 32'h1);
    chk("bresp", 32'(r), 32'h2);
    axw(8'h04, 32'h100);
    axr(8'h04);
    chk("base", d, 32'h100);
    axw(8'h14, 32'h7);
    axw(8'h00, 32'h1);
    $display("register test done");
    frm(32'h1000, 32'h40, 32'h2000, 32'h80, 9'h0C1, 32'h110, 32'h3100);
    axr(8'h0C);
    chk("status", d, 32'h0);
    chk("irq", 32'(irq), 32'h0);
    slow <= 1;
    frm(32'h1100, 32'h20, 32'h300, 32'h0, 9'h113, 32'h130, 32'h4380);
    frm(32'h1200, 32'h10, 32'h500, 32'h0, 9'h022, 32'h350, 32'h0240);
    do @(posedge aclk); while (!buf_valid);
    chk("wrap_buf1", buf1_addr, 32'h1000);
    chk("wrap_rd_addr", mem_rd_addr, 32'h10C);
    ce <= 0;
    frame_end <= 1;
    @(posedge aclk);
    frame_end <= 0;
    repeat (3) @(posedge aclk);
    ce <= 1;
    @(posedge aclk);
    chk("ce_freeze", 32'(buf_valid), 32'h1);
    axr(8'h08);
    chk("cur", d, 32'h100);
    axr(8'h0C);
    chk("status", d, 32'h7);
    chk("irq", 32'(irq), 32'h1);
    axw(8'h10, 32'h1);
    axr(8'h0C);
    chk("status_clr", d, 32'h6);
    axw(8'h14, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq_masked", 32'(irq), 32'h0);
    $display("ring test done");
    print_verdict();
  end
endmodule : eth_rx_descriptor_fetch_tb_top

// ===== verif/rx_desc_fetch_sva.sv
`timescale 1ns/1ns
module rx_desc_fetch_sva import rx_desc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic mem_rd_req,
  input wire word_t mem_rd_addr,
  input wire logic mem_rd_valid,
  input wire logic mem_wr_req,
  input wire word_t mem_wr_data,
  input wire logic mem_wr_ack,
  input wire logic buf_valid,
  input wire bsize_t buf1_size,
  input wire bsize_t buf2_size,
  input wire logic frame_end
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rd_req_held: assert property (mem_rd_req && !mem_rd_valid |=>
    mem_rd_req && $stable(mem_rd_addr)) else $error("read request not held");
  a_wr_req_held: assert property (mem_wr_req && !mem_wr_ack |=>
    mem_wr_req && $stable(mem_wr_data)) else $error("write-back not held");
  a_frame_to_wb: assert property (ce && buf_valid && frame_end |=>
    !buf_valid ##[0:2] mem_wr_req) else $error("no write-back after frame");
  a_wb_rsv_zero: assert property (mem_wr_req |->
    mem_wr_data[31:15] == 17'h0 && mem_wr_data[5:0] == 6'h0) else $error("word4 spare bits set");
  a_eth_no_ip: assert property (mem_wr_req && mem_wr_data[12] |->
    mem_wr_data[7:6] == 2'h0) else $error("ip bits set for ethernet carrier");
  a_untyped_clean: assert property (mem_wr_req && mem_wr_data[11:8] == 4'h0 |->
    !mem_wr_data[12] && mem_wr_data[7:6] == 2'h0) else $error("carrier bits without type");
  a_offer_nonempty: assert property (buf_valid |->
    buf1_size != 13'h0 || buf2_size != 13'h0) else $error("empty descriptor offered");
  a_offer_steady: assert property (buf_valid && !frame_end |=> buf_valid &&
    $stable(buf1_size) && $stable(buf2_size)) else $error("buffer offer changed");
endmodule : rx_desc_fetch_sva

bind eth_rx_descriptor_fetch rx_desc_fetch_sva u_sva (.aclk, .aresetn, .ce, .mem_rd_req,
  .mem_rd_addr, .mem_rd_valid, .mem_wr_req, .mem_wr_data, .mem_wr_ack, .buf_valid,
  .buf1_size, .buf2_size, .frame_end);

// ===== verif/rx_host_mem_model.sv
`timescale 1ns/1ns
module rx_host_mem_model import rx_desc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic mem_rd_req,
  input wire word_t mem_rd_addr,
  output logic mem_rd_valid,
  output word_t mem_rd_data,
  input wire logic mem_wr_req,
  input wire word_t mem_wr_addr,
  input wire word_t mem_wr_data,
  output logic mem_wr_ack
);
  word_t mem [0:511];
  logic [1:0] wait_q;
  // answers at once or after three idle cycles; idle data churns
  always @(posedge aclk) begin
    mem_rd_valid <= 1'b0;
    mem_wr_ack <= 1'b0;
    mem_rd_data <= ~mem_rd_data;
    if (!aresetn) begin
      wait_q <= 2'h0;
      mem_rd_data <= 32'h0;
    end else if ((mem_rd_req && !mem_rd_valid) || (mem_wr_req && !mem_wr_ack)) begin
      wait_q <= wait_q + 2'h1;
      if (!slow || wait_q == 2'h3) begin
        wait_q <= 2'h0;
        mem_rd_valid <= mem_rd_req;
        mem_wr_ack <= mem_wr_req && !mem_rd_req;
        mem_rd_data <= mem[mem_rd_addr[10:2]];
        if (mem_wr_req && !mem_rd_req) mem[mem_wr_addr[10:2]] <= mem_wr_data;
      end
    end
  end
endmodule : rx_host_mem_model
